// ---- hw/i2c_target_params.svh ----
// constants for the two-wire target: address, pointer reset, bits per byte, fifo size
// assumes inclusion by bare name from design and bench files
`ifndef I2C_TARGET_PARAMS_SVH
`define I2C_TARGET_PARAMS_SVH
`define TARGET_ADDR 7'h35
`define PTR_RESET 8'h00
`define BITS_PER_BYTE 4'h8
`define FIFO_DEPTH 8
`define FIFO_WIDTH 16
`endif

// ---- hw/i2c_target_pkg.sv ----
// types shared by the two-wire target logic
// uses no constants from the params header
package i2c_target_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_ack, st_rx, st_tx, st_tx_ack, st_skip
  } phase_t;
endpackage

// ---- hw/i2c_target.sv ----
// two-wire target with register pointer, write fifo toward the register file
// assumes scl and sda come from pins; register file answers reads combinationally
//
// Behaviour
// - first written byte loads the register pointer unless the write fifo is full
// - stop after pointer byte changes no register
// - data bytes stored at pointer, pointer increments, unless the write fifo is full
// - read starts at previously stored pointer
// - pointer increments after each transmitted byte
// - after master nack, stop driving data
// - reset puts interface and pointer in defined state
// - answer only to address 0110101
// - acknowledge received bytes on ninth clock; bytes after the address nacked while the write fifo is full
`timescale 1ns/1ps
`include "i2c_target_params.svh"

// ----------------------------------------
// fifo
// ----------------------------------------
module sync_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// target
// ----------------------------------------
module i2c_target (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic [7:0] pointer,
  output logic busy
);
  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl = scl_sync_reg[1];
  assign sda = sda_sync_reg[1];
  assign scl_rise = scl && !scl_d_reg;
  assign scl_fall = !scl && scl_d_reg;
  assign start_cond = scl && scl_d_reg && !sda && sda_d_reg;
  assign stop_cond = scl && scl_d_reg && sda && !sda_d_reg;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  i2c_target_pkg::phase_t state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic read_reg;
  logic first_reg;
  logic [7:0] ptr_reg;
  logic push_reg;
  logic [7:0] push_addr_reg;
  logic [7:0] push_data_reg;
  logic fifo_ready;
  logic byte_done;
  assign byte_done = scl_fall && bit_reg == `BITS_PER_BYTE;

  // bytes land as full sampled bytes on the eighth-clock falling edge before ack
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= i2c_target_pkg::st_idle;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_reg <= 1'b0;
      first_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= i2c_target_pkg::st_addr;
      bit_reg <= 4'h0;
    end else if (stop_cond) begin
      state_reg <= i2c_target_pkg::st_idle;
    end else begin
      case (state_reg)
        i2c_target_pkg::st_addr, i2c_target_pkg::st_rx: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_reg <= bit_reg + 4'h1;
          end else if (byte_done) begin
            bit_reg <= 4'h0;
            if (state_reg == i2c_target_pkg::st_addr) begin
              if (shift_reg[7:1] == `TARGET_ADDR) begin
                read_reg <= shift_reg[0];
                first_reg <= 1'b1;
                state_reg <= i2c_target_pkg::st_ack;
              end else begin
                state_reg <= i2c_target_pkg::st_skip;
              end
            end else if (!fifo_ready) begin
              state_reg <= i2c_target_pkg::st_skip; // full fifo: nack
            end else begin
              state_reg <= i2c_target_pkg::st_ack;
            end
          end
        end
        i2c_target_pkg::st_ack: begin
          if (scl_fall) begin
            first_reg <= first_reg && read_reg ? 1'b0 : first_reg;
            state_reg <= read_reg ? i2c_target_pkg::st_tx : i2c_target_pkg::st_rx;
            if (read_reg) begin
              shift_reg <= rd_data;
            end
          end
        end
        i2c_target_pkg::st_tx: begin
          if (scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b1};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              state_reg <= i2c_target_pkg::st_tx_ack;
              bit_reg <= 4'h0;
            end
          end
        end
        i2c_target_pkg::st_tx_ack: begin
          if (scl_rise) begin
            state_reg <= sda ? i2c_target_pkg::st_skip : i2c_target_pkg::st_ack;
          end
        end
        default: begin
        end
      endcase
      if (state_reg == i2c_target_pkg::st_rx && byte_done && fifo_ready) begin
        first_reg <= 1'b0;
      end
    end
  end

  // pointer and write requests
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_reg <= `PTR_RESET;
      push_reg <= 1'b0;
      push_addr_reg <= 8'h00;
      push_data_reg <= 8'h00;
    end else begin
      push_reg <= 1'b0;
      if (state_reg == i2c_target_pkg::st_rx && byte_done && fifo_ready) begin
        if (first_reg) begin
          ptr_reg <= shift_reg;
        end else begin
          push_reg <= 1'b1;
          push_addr_reg <= ptr_reg;
          push_data_reg <= shift_reg;
          ptr_reg <= ptr_reg + 8'h01;
        end
      end else if (state_reg == i2c_target_pkg::st_tx && scl_fall && bit_reg == 4'h7) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  // sda: low enable drives low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sda_oe_n <= 1'b1;
    end else if (state_reg == i2c_target_pkg::st_ack && !read_reg) begin
      sda_oe_n <= 1'b0;
    end else if (state_reg == i2c_target_pkg::st_ack && read_reg && first_reg) begin
      sda_oe_n <= 1'b0;
    end else if (state_reg == i2c_target_pkg::st_tx) begin
      sda_oe_n <= shift_reg[7];
    end else begin
      sda_oe_n <= 1'b1;
    end
  end
  assign sda_out = 1'b0;

  sync_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) wr_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .in_data({push_addr_reg, push_data_reg}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  assign rd_addr = ptr_reg;
  assign rd_strobe = state_reg == i2c_target_pkg::st_ack && read_reg && scl_fall;
  assign pointer = ptr_reg;
  assign busy = state_reg != i2c_target_pkg::st_idle;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ptr_load: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_rx && byte_done && fifo_ready && first_reg)
    |=> ptr_reg == $past(shift_reg)) else $error("pointer not loaded");
  a_write_push: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_rx && byte_done && fifo_ready && !first_reg)
    |=> push_reg && ptr_reg == $past(ptr_reg) + 8'h01) else $error("write not stored");
  a_no_push_ptr: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_rx && first_reg) |=> !push_reg)
    else $error("register written by pointer byte");
  a_ptr_hold: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == i2c_target_pkg::st_idle && $past(state_reg) == i2c_target_pkg::st_idle
    |-> $stable(ptr_reg)) else $error("pointer moved while idle");
  a_read_inc: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_tx && scl_fall && bit_reg == 4'h7)
    |=> ptr_reg == $past(ptr_reg) + 8'h01) else $error("read pointer not advanced");
  a_nack_release: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == i2c_target_pkg::st_skip |=> sda_oe_n) else $error("driving after nack");
  a_addr_match: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_addr && byte_done && shift_reg[7:1] != `TARGET_ADDR)
    |=> state_reg == i2c_target_pkg::st_skip) else $error("foreign address acked");
  a_ack_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == i2c_target_pkg::st_ack && !read_reg) ##1
    (state_reg == i2c_target_pkg::st_ack) |-> !sda_oe_n) else $error("no ack driven");
  a_reset_idle: assert property (@(posedge clock)
    !rst_n |=> state_reg == i2c_target_pkg::st_idle && sda_oe_n) else $error("reset state");
  c_write: cover property (@(posedge clock) push_reg);
  c_read: cover property (@(posedge clock) rd_strobe);
  c_nack: cover property (@(posedge clock) state_reg == i2c_target_pkg::st_tx_ack ##1
    state_reg == i2c_target_pkg::st_skip);
  c_full: cover property (@(posedge clock) !fifo_ready);
endmodule

// ---- test/i2c_master_model.sv ----
// bus master model: drives scl, pulls sda low open-drain, samples sda
// assumes the bench resolves sda with a pull-up and runs a 20 ns clock
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clock,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // ----------------------------------------
  // bit level, 8 clocks = 160 ns a bit
  // ----------------------------------------
  // sda moves one clock after scl falls, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic seen);
    scl <= 1'b0;
    hold(1);
    sda_low <= ~b;
    hold(3);
    scl <= 1'b1;
    hold(2);
    seen = sda;
    hold(2);
  endtask
  // serves as a first or a repeated start
  task automatic start();
    scl <= 1'b0;
    hold(4);
    sda_low <= 1'b0;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda_low <= 1'b1;
    hold(4);
  endtask
  task automatic stop();
    scl <= 1'b0;
    hold(1);
    sda_low <= 1'b1;
    hold(3);
    scl <= 1'b1;
    hold(4);
    sda_low <= 1'b0;
    hold(4);
  endtask
  // ----------------------------------------
  // byte level, msb first
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, nack);
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench: master model, open-drain sda, register file model
// assumes the bench answers rd_data combinationally from its register file model
`timescale 1ns/1ps
`include "i2c_target_params.svh"
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wr_ready = 1'b0;
  logic stall = 1'b0;
  logic scl, sda_low, sda, sda_out, sda_oe_n, wr_valid, rd_strobe, busy;
  logic [7:0] wr_addr, wr_data, rd_addr, pointer, exp_ptr;
  logic [7:0] regs [256];
  logic [7:0] exp_regs [256];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 clock = ~clock;
  assign sda = ~sda_low & (sda_oe_n | sda_out);
  i2c_master_model master (.clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));
  i2c_target DUT (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(regs[rd_addr]),
    .rd_strobe(rd_strobe), .pointer(pointer), .busy(busy));
  // register file stalls at random so the fifo really buffers
  always @(posedge clock) begin
    wr_ready <= ~stall & ($urandom_range(3) != 0);
    if (wr_valid && wr_ready) regs[wr_addr] <= wr_data;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic compare_all();
    for (int i = 0; i < 256; i++) check(regs[i], exp_regs[i]);
  endtask
  task automatic address(input logic rw);
    logic nk;
    master.send_byte({`TARGET_ADDR, rw}, nk);
    check(8'(nk), 8'h0);
  endtask
  // a full fifo refuses the byte and leaves the pointer where it was
  function automatic logic byte_taken(input int k);
    return !(stall && k >= `FIFO_DEPTH);
  endfunction
  // while stalled, bytes past the fifo depth must be refused
  task automatic write_regs(input logic [7:0] p, input int n);
    logic nk;
    logic [7:0] d;
    master.start();
    address(1'b0);
    master.send_byte(p, nk);
    check(8'(nk), 8'h0);
    exp_ptr = p;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      master.send_byte(d, nk);
      check(8'(nk), 8'(!byte_taken(k)));
      if (byte_taken(k)) begin
        exp_regs[exp_ptr] = d;
        exp_ptr++;
      end
    end
    master.stop();
    for (int i = 0; i < 100 && wr_valid !== 1'b0; i++) @(negedge clock);
    check(pointer, exp_ptr);
    $display("done: write of %0d bytes at %h", n, p);
  endtask
  task automatic read_regs(input logic set_ptr, input logic [7:0] p, input int n);
    logic nk;
    logic [7:0] d;
    int lows;
    if (set_ptr) begin
      master.start();
      address(1'b0);
      master.send_byte(p, nk);
      check(8'(nk), 8'h0);
      exp_ptr = p;
    end
    master.start();
    address(1'b1);
    for (int k = 0; k < n; k++) begin
      master.recv_byte(k == n - 1, d);
      check(d, exp_regs[exp_ptr]);
      exp_ptr++;
    end
    lows = 0;
    fork
      master.stop();
      repeat (12) begin
        @(negedge clock);
        if (sda_oe_n !== 1'b1) lows++;
      end
    join
    check(8'(lows), 8'h0);
    check(pointer, exp_ptr);
    $display("done: read of %0d bytes", n);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic nk;
    void'($urandom(32'hd168));
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($urandom);
      exp_regs[i] = regs[i];
    end
    hold(2);
    @(negedge clock);
    check(8'({sda_oe_n, wr_valid, busy}), 8'h4);
    check(pointer, `PTR_RESET);
    @(posedge clock) rst_n <= 1'b1;
    hold(4);
    master.stop();
    write_regs(8'hfe, 4);
    compare_all();
    write_regs(8'h10, 0);
    compare_all();
    read_regs(1'b0, 8'h00, 3);
    read_regs(1'b0, 8'h00, 2);
    repeat (6) begin
      write_regs(8'($urandom), $urandom_range(5, 1));
      compare_all();
      read_regs(1'b1, 8'($urandom), $urandom_range(4, 1));
    end
    master.start();
    master.send_byte({`TARGET_ADDR ^ 7'h01, 1'b0}, nk);
    check(8'(nk), 8'h1);
    master.send_byte(8'h00, nk);
    check(8'(nk), 8'h1);
    master.stop();
    check(pointer, exp_ptr);
    $display("done: foreign address ignored");
    stall <= 1'b1;
    hold(2);
    write_regs(8'h40, `FIFO_DEPTH + 1);
    stall <= 1'b0;
    for (int i = 0; i < 100 && wr_valid !== 1'b0; i++) @(negedge clock);
    compare_all();
    // reset in mid-run while the pointer is away from its reset value
    @(posedge clock) rst_n <= 1'b0;
    hold(2);
    @(negedge clock);
    check(8'({sda_oe_n, wr_valid, busy}), 8'h4);
    check(pointer, `PTR_RESET);
    @(posedge clock) rst_n <= 1'b1;
    hold(4);
    $display("done: reset in mid-run");
    exp_ptr = `PTR_RESET;
    read_regs(1'b0, 8'h00, 2);
    read_regs(1'b1, 8'h40, 4);
    end_of_test();
  end
endmodule
